// ===== src/pwm_freq_top.sv
// Frequency output and 9/10/11-bit pulse width modes of the counter array modules,
// with the cycle configuration register on the special function register bus.
// Assumes the shared counter block supplies the counter value and a one-cycle tick
// in the clock where the counter has just taken its new value.
`timescale 1ns/1ps
`include "pca_regs.svh"

module pwm_freq_top (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire pca_pkg::sfr_req_s sfr_req,
  input wire logic [15:0] array_main_counter,
  input wire logic counter_tick,
  input wire pca_pkg::mod_ctl_s [`NUM_MOD-1:0] mod_ctl,
  output logic [7:0] sfr_rdata,
  output logic [`NUM_MOD-1:0] module_output_pin,
  output logic [`NUM_MOD-1:0] module_event_set,
  output logic [`NUM_MOD-1:0] comparator_enable,
  output logic counter_irq
);
  import pca_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // State

  typedef struct packed {
    cfg_s cfg;
    logic [`NUM_MOD-1:0] pin;
    logic [`NUM_MOD-1:0] evt;
    logic irq;
    logic [7:0] rdata;
  } top_s;

  top_s s_q;
  top_s s_d;

  // Compare bank ports
  logic [`NUM_MOD-1:0] wr_lo;
  logic [`NUM_MOD-1:0] wr_hi;
  logic [`NUM_MOD-1:0] reload_now;
  logic [`NUM_MOD-1:0] lo_load;
  logic [7:0] lo_val [`NUM_MOD];
  logic [15:0] cp [`NUM_MOD];
  logic [15:0] ar [`NUM_MOD];
  logic [`NUM_MOD-1:0] ecom;

  // Shared cycle signals
  logic [10:0] mask;
  logic [10:0] cnt_low;
  logic cycle_ovf;
  logic cfg_wr;
  logic cfg_rd;

  ////////////////////////////////////////////////////////////////////////////
  // Address decode, used for both write routing and read mux

  function automatic logic is_lo_addr(input logic [7:0] a, input int idx);
    logic [7:0] base;
    base = `CP_LO_BASE + 8'(idx) * `CP_STRIDE;
    return a == base;
  endfunction

  function automatic logic is_hi_addr(input logic [7:0] a, input int idx);
    logic [7:0] base;
    base = `CP_HI_BASE + 8'(idx) * `CP_STRIDE;
    return a == base;
  endfunction

  // Configuration register image as software sees it
  function automatic logic [7:0] cfg_image(input cfg_s c);
    logic [7:0] v;
    v = 8'h00;
    v[`CFG_RELOAD_BANK_SELECT_BIT] = c.reload_bank_select;
    v[`CFG_OVERFLOW_IRQ_ENABLE_BIT] = c.overflow_irq_enable;
    v[`CFG_CYCLE_OVERFLOW_FLAG_BIT] = c.cycle_overflow_flag;
    v[`CFG_CLSEL_LSB +: 2] = c.cycle_length_select;
    return v;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Cycle boundary detect

  // Overflow out of bit N shows as the low N bits wrapping to zero
  always_comb begin
    mask = cycle_mask(s_q.cfg.cycle_length_select);
    cnt_low = array_main_counter[10:0] & mask;
    cycle_ovf = counter_tick && (cnt_low == 11'h000);
    cfg_wr = sfr_req.wr && (sfr_req.addr == `CFG_ADDR);
    cfg_rd = sfr_req.rd && (sfr_req.addr == `CFG_ADDR);
  end

  ////////////////////////////////////////////////////////////////////////////
  // Compare bank write strobes

  always_comb begin
    for (int i = 0; i < `NUM_MOD; i++) begin
      wr_lo[i] = sfr_req.wr && is_lo_addr(sfr_req.addr, i);
      wr_hi[i] = sfr_req.wr && is_hi_addr(sfr_req.addr, i);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Compare banks, one per module

  genvar g;
  generate
    for (g = 0; g < `NUM_MOD; g++) begin : gen_bank
      compare_bank u_bank (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .wr_lo(wr_lo[g]),
        .wr_hi(wr_hi[g]),
        .bank_sel(s_q.cfg.reload_bank_select),
        .wdata(sfr_req.wdata),
        .reload_now(reload_now[g]),
        .lo_load(lo_load[g]),
        .lo_val(lo_val[g]),
        .compare_value(cp[g]),
        .reload_value(ar[g]),
        .comparator_enable(ecom[g])
      );
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Configuration register, module outputs, read data, interrupt

  always_comb begin
    chan_mode_e mode;
    logic [7:0] w;
    logic ovf_set;
    mode = MODE_OTHER;
    w = sfr_req.wdata;
    ovf_set = 1'b0;
    s_d = s_q;

    // Software write; flag bit can be set or cleared here
    if (cfg_wr) begin
      s_d.cfg.reload_bank_select = w[`CFG_RELOAD_BANK_SELECT_BIT];
      s_d.cfg.overflow_irq_enable = w[`CFG_OVERFLOW_IRQ_ENABLE_BIT];
      s_d.cfg.cycle_overflow_flag = w[`CFG_CYCLE_OVERFLOW_FLAG_BIT];
      s_d.cfg.cycle_length_select = w[`CFG_CLSEL_LSB +: 2];
    end

    // Per-module compare behaviour
    for (int i = 0; i < `NUM_MOD; i++) begin
      mode = decode_mode(ecom[i], mod_ctl[i], s_q.cfg.cycle_length_select);
      reload_now[i] = 1'b0;
      lo_load[i] = 1'b0;
      lo_val[i] = cp[i][7:0];
      s_d.evt[i] = 1'b0;
      case (mode)
        MODE_FREQ: begin
          if (counter_tick && array_main_counter[7:0] == cp[i][7:0]) begin
            s_d.pin[i] = ~s_q.pin[i];
            // 8-bit sum wraps, so a zero high byte steps a full 256
            lo_val[i] = cp[i][7:0] + cp[i][15:8];
            lo_load[i] = 1'b1;
          end
          if (counter_tick && mod_ctl[i].match_flag_enable && array_main_counter == cp[i]) begin
            s_d.evt[i] = 1'b1;
          end
        end
        MODE_NBIT: begin
          if (cycle_ovf) begin
            s_d.pin[i] = 1'b0;
            reload_now[i] = 1'b1;
          end
          // Match after the low drive: a zero compare gives full duty
          if (counter_tick && cnt_low == (cp[i][10:0] & mask)) begin
            s_d.pin[i] = 1'b1;
            s_d.evt[i] = mod_ctl[i].match_flag_enable;
          end
        end
        MODE_OTHER: begin
          // Reload value has no effect here
          reload_now[i] = 1'b0;
        end
        default: begin
          reload_now[i] = 1'b0;
        end
      endcase
    end

    // Flag tracks the selected bit in every mode; hardware set beats a clear
    ovf_set = cycle_ovf;
    if (ovf_set) begin
      s_d.cfg.cycle_overflow_flag = 1'b1;
    end

    // Interrupt follows the next flag through the enable
    s_d.irq = s_d.cfg.overflow_irq_enable && s_d.cfg.cycle_overflow_flag;

    // Read data captured on the read strobe; unmapped reads give zero
    if (sfr_req.rd) begin
      s_d.rdata = 8'h00;
      if (cfg_rd) begin
        s_d.rdata = cfg_image(s_q.cfg);
      end
      for (int i = 0; i < `NUM_MOD; i++) begin
        if (is_lo_addr(sfr_req.addr, i)) begin
          s_d.rdata = s_q.cfg.reload_bank_select ? ar[i][7:0] : cp[i][7:0];
        end
        if (is_hi_addr(sfr_req.addr, i)) begin
          s_d.rdata = s_q.cfg.reload_bank_select ? ar[i][15:8] : cp[i][15:8];
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      s_q.cfg <= cfg_s'(5'h00);
      s_q.pin <= '0;
      s_q.evt <= '0;
      s_q.irq <= 1'b0;
      s_q.rdata <= 8'h00;
    end else begin
      s_q <= s_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs, all from flip-flops

  assign sfr_rdata = s_q.rdata;
  assign module_output_pin = s_q.pin;
  assign module_event_set = s_q.evt;
  assign comparator_enable = ecom;
  assign counter_irq = s_q.irq;

endmodule

// ===== src/pca_regs.svh
// Constants for the frequency output and 9/10/11-bit pulse width slice of the counter array.
// Assumes the includer supplies the counter value and counter tick from the shared counter block.
`ifndef PCA_REGS_SVH
`define PCA_REGS_SVH

// Register addresses
`define CFG_ADDR 8'hF4
`define CP_LO_BASE 8'hE9
`define CP_HI_BASE 8'hEA
`define CP_STRIDE 8'h02
`define NUM_MOD 2

// Configuration field positions
`define CFG_RELOAD_BANK_SELECT_BIT 7
`define CFG_OVERFLOW_IRQ_ENABLE_BIT 6
`define CFG_CYCLE_OVERFLOW_FLAG_BIT 5
`define CFG_CLSEL_LSB 0
`define CFG_RESET 8'h00

// Cycle masks for 8, 9, 10 and 11-bit lengths
`define MASK_8 11'h0FF
`define MASK_9 11'h1FF
`define MASK_10 11'h3FF
`define MASK_11 11'h7FF

// Compare bank reset values
`define CP_RESET 16'h0000
`define AR_RESET 16'h0000

`endif

// ===== src/pca_pkg.sv
// Types shared by the pulse width top and its compare bank.
// Assumes pca_regs.svh is on the include path.
`include "pca_regs.svh"

package pca_pkg;

  // Special function register access, one cycle per strobe
  typedef struct packed {
    logic [7:0] addr;
    logic wr;
    logic rd;
    logic [7:0] wdata;
  } sfr_req_s;

  // Per-module mode bits kept in the module mode register elsewhere
  typedef struct packed {
    logic toggle_enable;
    logic pulse_width_enable;
    logic match_flag_enable;
  } mod_ctl_s;

  // Cycle configuration register contents
  typedef struct packed {
    logic reload_bank_select;
    logic overflow_irq_enable;
    logic cycle_overflow_flag;
    logic [1:0] cycle_length_select;
  } cfg_s;

  typedef enum logic [1:0] {
    MODE_OTHER,
    MODE_FREQ,
    MODE_NBIT
  } chan_mode_e;

  // Mode decode from the enables and the cycle length
  function automatic chan_mode_e decode_mode(input logic ecom, input mod_ctl_s ctl, input logic [1:0] clsel);
    chan_mode_e m;
    m = MODE_OTHER;
    if (ecom && ctl.toggle_enable && ctl.pulse_width_enable) begin
      m = MODE_FREQ;
    end else if (ecom && ctl.pulse_width_enable && !ctl.toggle_enable && clsel != 2'b00) begin
      m = MODE_NBIT;
    end
    return m;
  endfunction

  // Counter bits that make up one cycle
  function automatic logic [10:0] cycle_mask(input logic [1:0] clsel);
    logic [10:0] m;
    m = `MASK_8;
    case (clsel)
      2'b00: m = `MASK_8;
      2'b01: m = `MASK_9;
      2'b10: m = `MASK_10;
      2'b11: m = `MASK_11;
      default: m = `MASK_8;
    endcase
    return m;
  endfunction

endpackage

// ===== src/compare_bank.sv
// Compare value and auto-reload value of one module, with its comparator enable.
// Assumes write strobes are one-cycle pulses already decoded by the top.
`timescale 1ns/1ps
`include "pca_regs.svh"

module compare_bank (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic wr_lo,
  input wire logic wr_hi,
  input wire logic bank_sel,
  input wire logic [7:0] wdata,
  input wire logic reload_now,
  input wire logic lo_load,
  input wire logic [7:0] lo_val,
  output logic [15:0] compare_value,
  output logic [15:0] reload_value,
  output logic comparator_enable
);
  import pca_pkg::*;

  typedef struct packed {
    logic [15:0] cp;
    logic [15:0] ar;
    logic ecom;
  } bank_s;

  bank_s s_q;
  bank_s s_d;

  ////////////////////////////////////////////////////////////////////////////
  // Next state: software writes first, hardware updates override
  always_comb begin
    s_d = s_q;
    if (wr_lo) begin
      if (bank_sel) begin
        s_d.ar[7:0] = wdata;
      end else begin
        s_d.cp[7:0] = wdata;
      end
      s_d.ecom = 1'b0;
    end
    if (wr_hi) begin
      if (bank_sel) begin
        s_d.ar[15:8] = wdata;
      end else begin
        s_d.cp[15:8] = wdata;
      end
      s_d.ecom = 1'b1;
    end
    // Hardware wins so a cycle boundary never skips a reload
    if (reload_now) begin
      s_d.cp = s_q.ar;
    end
    if (lo_load) begin
      s_d.cp[7:0] = lo_val;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      s_q <= '{cp: `CP_RESET, ar: `AR_RESET, ecom: 1'b0};
    end else begin
      s_q <= s_d;
    end
  end

  assign compare_value = s_q.cp;
  assign reload_value = s_q.ar;
  assign comparator_enable = s_q.ecom;

endmodule

// ===== testbench/pwm_freq_sva.sv
// Port-level checker for the frequency output and pulse width top.
// Assumes it is bound to pwm_freq_top and that the register header is reachable.
`timescale 1ns/1ps
`include "pca_regs.svh"
module pwm_freq_sva (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire pca_pkg::sfr_req_s sfr_req,
  input wire logic [15:0] array_main_counter,
  input wire logic counter_tick,
  input wire pca_pkg::mod_ctl_s [`NUM_MOD-1:0] mod_ctl,
  input wire logic [7:0] sfr_rdata,
  input wire logic [`NUM_MOD-1:0] module_output_pin,
  input wire logic [`NUM_MOD-1:0] module_event_set,
  input wire logic [`NUM_MOD-1:0] comparator_enable,
  input wire logic counter_irq
);
  import pca_pkg::*;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  ////////////////////////////////////////////////////////////
  // Bus cycles the properties start from
  sequence cfg_wr; sfr_req.wr && sfr_req.addr == 8'hF4; endsequence
  sequence cfg_rd; sfr_req.rd && sfr_req.addr == 8'hF4; endsequence
  sequence lo_wr; sfr_req.wr && sfr_req.addr == 8'hE9; endsequence
  sequence hi_wr; sfr_req.wr && sfr_req.addr == 8'hEA; endsequence
  logic cp_wr;
  // Any compare byte write, either module
  assign cp_wr = sfr_req.wr && (sfr_req.addr inside {8'hE9, 8'hEA, 8'hEB, 8'hEC});
  ////////////////////////////////////////////////////////////
  lo_clear_a: assert property (lo_wr |=> !comparator_enable[0])
    else $error("low byte write left enable set");
  hi_set_a: assert property (hi_wr |=> comparator_enable[0])
    else $error("high byte write left enable clear");
  en_hold_a: assert property (!cp_wr |=> $stable(comparator_enable))
    else $error("enable moved without a compare write");
  cfg_zero_a: assert property (cfg_rd |=> sfr_rdata[4:2] == 3'b000)
    else $error("unused config bits read nonzero");
  irq_off_a: assert property (cfg_wr ##0 !sfr_req.wdata[6] |-> ##[1:2] !counter_irq)
    else $error("interrupt stayed with enable off");
  irq_on_a: assert property (cfg_wr ##0 (sfr_req.wdata[6] && sfr_req.wdata[5]) |-> ##[1:2] counter_irq)
    else $error("software flag set gave no interrupt");
  irq_fall_a: assert property ($fell(counter_irq) && $past(rst_n) |-> $past(sfr_req.wr) || $past(sfr_req.wr, 2))
    else $error("interrupt dropped without a write");
  pin_tick_a: assert property ($past(rst_n) && !$past(counter_tick) |-> $stable(module_output_pin))
    else $error("pin moved without a counter tick");
  evt_tick_a: assert property (module_event_set != 2'b00 |-> $past(counter_tick))
    else $error("event without a counter tick");
  evt_pulse_a: assert property (module_event_set[0] |=> !module_event_set[0])
    else $error("event longer than one cycle");
endmodule

bind pwm_freq_top pwm_freq_sva chk (.clk_sys(clk_sys), .rst_n(rst_n), .sfr_req(sfr_req),
  .array_main_counter(array_main_counter), .counter_tick(counter_tick), .mod_ctl(mod_ctl),
  .sfr_rdata(sfr_rdata), .module_output_pin(module_output_pin), .module_event_set(module_event_set),
  .comparator_enable(comparator_enable), .counter_irq(counter_irq));

// ===== testbench/pin_load.sv
// Load on the module output pins: counts level changes of module 0.
// Assumes the pins are registered on the rising edge of clk_sys.
`timescale 1ns/1ps
`include "pca_regs.svh"
module pin_load (
  input wire logic clk_sys,
  input wire logic [`NUM_MOD-1:0] pin,
  output int unsigned edges
);
  logic last_q;
  ////////////////////////////////////////////////////////////
  // Seen edges give the square wave rate, not only its level
  initial begin
    edges = 0;
    last_q = 1'b0;
  end
  always @(posedge clk_sys) begin
    if (pin[0] !== last_q) edges <= edges + 1;
    last_q <= pin[0];
  end
endmodule

// ===== testbench/tb_pwm_freq_top.sv
// Self-checking bench for the frequency output and pulse width top.
// Assumes the counter is modelled here and ticks every second cycle.
`timescale 1ns/1ps
`include "pca_regs.svh"
module tb_pwm_freq_top;
  import pca_pkg::*;
  logic clk_sys, rst_n, counter_tick, counter_irq, exp_pin, ev;
  sfr_req_s sfr_req;
  logic [15:0] array_main_counter, rnd, cp, ar;
  mod_ctl_s [`NUM_MOD-1:0] mod_ctl;
  logic [7:0] sfr_rdata, rd_v, lo, hi, ad;
  logic [10:0] k;
  logic [`NUM_MOD-1:0] module_output_pin, module_event_set, comparator_enable;
  int unsigned edges, e0, nt;
  int err_total, samples_checked, m;
  pwm_freq_top dut (.clk_sys(clk_sys), .rst_n(rst_n), .sfr_req(sfr_req),
    .array_main_counter(array_main_counter), .counter_tick(counter_tick), .mod_ctl(mod_ctl),
    .sfr_rdata(sfr_rdata), .module_output_pin(module_output_pin), .module_event_set(module_event_set),
    .comparator_enable(comparator_enable), .counter_irq(counter_irq));
  pin_load load (.clk_sys(clk_sys), .pin(module_output_pin), .edges(edges));
  initial begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end
  ////////////////////////////////////////////////////////////
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      err_total++;
      $display("Error %0t: byte %h, expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_bit(input logic got, input logic exp);
    samples_checked++;
    if (got !== exp) begin
      err_total++;
      $display("Error %0t: bit %b, expected %b", $time, got, exp);
    end
  endtask
  task automatic give_verdict;
    $display("checks %0d errors %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // Bus strobes last one cycle, inputs move on the falling edge
  task automatic sfr_wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk_sys);
    sfr_req = '{a, 1'b1, 1'b0, d};
    @(negedge clk_sys);
    sfr_req.wr = 1'b0;
  endtask
  task automatic sfr_rd(input logic [7:0] a);
    @(negedge clk_sys);
    sfr_req = '{a, 1'b0, 1'b1, 8'h00};
    @(negedge clk_sys);
    sfr_req.rd = 1'b0;
    rd_v = sfr_rdata;
  endtask
  task automatic tick;
    @(negedge clk_sys);
    array_main_counter = array_main_counter + 16'h0001;
    counter_tick = 1'b1;
    @(negedge clk_sys);
    counter_tick = 1'b0;
  endtask
  ////////////////////////////////////////////////////////////
  // Hang guard, well past the longest run
  initial begin
    #2000000;
    err_total++;
    give_verdict();
  end
  initial begin
    {rst_n, counter_tick, array_main_counter, sfr_req, mod_ctl} = '0;
    {err_total, samples_checked} = '0;
    rnd = 16'h002A;
    repeat (6) @(negedge clk_sys);
    rst_n = 1'b1;
    sfr_rd(8'hF4); chk_byte(rd_v, 8'h00);
    sfr_wr(8'hF4, 8'hFF);
    sfr_rd(8'hF4); chk_byte(rd_v, 8'hE3);
    chk_bit(counter_irq, 1'b1);
    sfr_wr(8'hF4, 8'h23);
    sfr_rd(8'h00); chk_byte(rd_v, 8'h00);
    chk_bit(counter_irq, 1'b0);
    exp_pin = 1'b0;
    // Every cycle length; length 8 is outside this block and must leave pin and compare alone
    for (int cl = 0; cl < 4; cl++) begin
      m = rnd[0];
      ad = 8'hE9 + 8'(2 * m);
      k = 11'h7FF >> (3 - cl);
      cp = (cl == 1) ? 16'h0000 : {5'h00, rnd[12:2] & k};
      rnd = lfsr(rnd);
      ar = {5'h00, rnd[10:0] & k};
      mod_ctl[m] = '{1'b0, 1'b1, rnd[3]};
      sfr_wr(8'hF4, 8'(cl));
      sfr_wr(ad, cp[7:0]); chk_bit(comparator_enable[m], 1'b0);
      sfr_wr(ad + 8'h01, cp[15:8]); chk_bit(comparator_enable[m], 1'b1);
      sfr_wr(8'hF4, 8'(cl) | 8'h80);
      sfr_wr(ad, ar[7:0]);
      sfr_wr(ad + 8'h01, ar[15:8]);
      sfr_rd(ad); chk_byte(rd_v, ar[7:0]);
      sfr_wr(8'hF4, 8'(cl));
      sfr_rd(ad + 8'h01); chk_byte(rd_v, cp[15:8]);
      array_main_counter = 16'hFFFF;
      repeat (2 * (int'(k) + 1)) begin
        tick();
        ev = (array_main_counter[10:0] & k) == cp[10:0] && cl != 0;
        if (cl != 0 && ev) exp_pin = 1'b1;
        else if (cl != 0 && (array_main_counter[10:0] & k) == 11'h000) exp_pin = 1'b0;
        if (cl != 0 && (array_main_counter[10:0] & k) == 11'h000) cp = ar;
        chk_bit(module_output_pin[m], exp_pin);
        chk_bit(module_event_set[m], ev && mod_ctl[m].match_flag_enable);
      end
      sfr_rd(8'hF4); chk_byte(rd_v, 8'h20 | 8'(cl));
      sfr_rd(ad); chk_byte(rd_v, cp[7:0]);
      sfr_wr(8'hF4, 8'h00);
      mod_ctl[m] = '0;
      rnd = lfsr(rnd);
    end
    // Frequency output, high byte zero as a corner then a random one
    for (int f = 0; f < 2; f++) begin
      lo = rnd[7:0];
      hi = (f == 0) ? 8'h00 : rnd[15:8] | 8'h01;
      // Second pass enables the match flag; both passes start just short of the full 16-bit match
      mod_ctl[0] = '{1'b1, 1'b1, 1'(f)};
      sfr_wr(8'hE9, lo);
      sfr_wr(8'hEA, hi);
      array_main_counter = {hi, lo} - 16'h0020;
      e0 = edges;
      nt = 0;
      repeat (600) begin
        tick();
        ev = f == 1 && array_main_counter == {hi, lo};
        if (array_main_counter[7:0] == lo) begin
          nt++;
          lo = lo + hi;
        end
        chk_bit(module_event_set[0], ev);
      end
      @(negedge clk_sys);
      chk_byte(8'(edges - e0), 8'(nt));
      sfr_rd(8'hE9); chk_byte(rd_v, lo);
      rnd = lfsr(rnd);
    end
    give_verdict();
  end
endmodule
